// ==== tb/pps_panel_model.sv ====
// Purpose: panel switches and backlight inverter at the far side
// Assumes: enables are active high, backlight_off_n low is dark
// Notes:   latches a fault, never clears it outside reset
`timescale 1ns/10ps
`default_nettype none
module pps_panel_model (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic panel_supply_enable,
    input  wire logic panel_data_enable,
    input  wire logic panel_contrast_enable,
    input  wire logic backlight_off_n,
    output logic      fault
);
    // ----
    // latch-up watch
    // ----
    // driving an unpowered panel can latch it up, so flag it
    always_ff @(posedge clock) begin
        if (reset) begin
            fault <= 1'b0;
        end else if (!panel_supply_enable && (panel_data_enable ||
                     panel_contrast_enable || backlight_off_n)) begin
            fault <= 1'b1;
        end
    end
endmodule : pps_panel_model
`default_nettype wire

// ==== tb/pps_panel_power_sequencer_tb.sv ====
// Purpose: directed bench for the panel power sequencer
// Assumes: phase counts cut to 10 and 40 cycles
// Notes:   one task per scenario, classic wishbone master
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    failures++; $display("BAD %s exp %h got %h", nm, e, g); end end
module pps_panel_power_sequencer_tb;
    localparam int          S   = 10;
    localparam int          L   = 40;
    localparam logic [11:0] REG = 12'h408;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [11:0] wb_adr = 12'h000;
    logic [31:0] wb_wdat = 32'h0000_0000;
    logic        ext_sup = 1'b0, ext_con = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, sup, dat, con, bl_n, busy, fault;
    wire  [3:0]  outs = {bl_n, con, dat, sup};
    int          failures = 0;
    int          tests_run = 0;
    always #50 clock = ~clock;
    pps_panel_power_sequencer #(.SHORT_COUNT(S), .LONG_COUNT(L),
        .TIMER_WIDTH(21)) pps_panel_power_sequencer_inst (
        .clock(clock), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ext_supply_request_in(ext_sup), .ext_contrast_request_in(ext_con),
        .panel_supply_enable(sup), .panel_data_enable(dat),
        .panel_contrast_enable(con), .backlight_off_n(bl_n),
        .sequence_busy(busy));
    pps_panel_model pps_panel_model_inst (.clock(clock), .reset(reset),
        .panel_supply_enable(sup), .panel_data_enable(dat),
        .panel_contrast_enable(con), .backlight_off_n(bl_n), .fault(fault));
    // ----
    // helpers
    // ----
    task automatic wb_xfer(input logic w, input logic [11:0] a,
                           input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        `CHK("wb_ack", 1'b1, wb_ack_o)
    endtask : wb_xfer
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb_xfer(1'b0, a, 32'h0000_0000, q);
        `CHK("rd_data", e, q)
    endtask : rd_chk
    // counts edges until output i reaches v; allows for timer skew
    task automatic dchk(input int i, input logic v, input int d);
        int n;
        n = 0;
        while (outs[i] !== v && n < d + 4) begin
            @(posedge clock);
            n++;
        end
        `CHK("phase_len", 1'b1, n >= d - 1 && n <= d + 3)
    endtask : dchk
    task automatic settle_chk(input logic [3:0] e);
        repeat (3) @(posedge clock);
        `CHK("outs", e, outs)
        `CHK("busy", 1'b0, busy)
    endtask : settle_chk
    // ----
    // scenarios
    // ----
    task automatic t_regs();
        rd_chk(REG, 32'h0000_0000);
        wr(REG, 32'h0800_0000);
        wr(REG, 32'hFFFF_FFFF);
        rd_chk(REG, 32'h0BFC_0000);
        wr(12'h40c, 32'h0000_0000);
        rd_chk(12'h40c, 32'h0000_0000);
        rd_chk(REG, 32'h0BFC_0000);
        settle_chk(4'h0);
    endtask : t_regs
    task automatic t_ext();
        ext_sup <= 1'b1;
        settle_chk(4'h3);
        ext_con <= 1'b1;
        settle_chk(4'h7);
        wr(REG, 32'h0800_0000);
        settle_chk(4'hf);
        ext_con <= 1'b0;
        settle_chk(4'h3);
        ext_sup <= 1'b0;
        settle_chk(4'h0);
        wr(REG, 32'h0000_0000);
        settle_chk(4'h0);
    endtask : t_ext
    task automatic t_up_down();
        wr(REG, 32'h0180_0000);
        dchk(0, 1'b1, 1);
        dchk(1, 1'b1, L);
        dchk(2, 1'b1, S);
        dchk(3, 1'b1, S);
        rd_chk(REG, 32'h0180_0000);
        wr(REG, 32'h0180_0000);
        settle_chk(4'hf);
        wr(REG, 32'h0380_0000);
        settle_chk(4'h7);
        wr(REG, 32'h0180_0000);
        settle_chk(4'hf);
        wr(REG, 32'h0010_0000);
        dchk(3, 1'b0, 1);
        dchk(2, 1'b0, L);
        dchk(1, 1'b0, S);
        dchk(0, 1'b0, S);
        rd_chk(REG, 32'h0010_0000);
    endtask : t_up_down
    task automatic t_indep();
        wr(REG, 32'h0320_0000);
        dchk(0, 1'b1, 1);
        dchk(1, 1'b1, S);
        dchk(2, 1'b1, S);
        settle_chk(4'h7);
        wr(REG, 32'h0210_0000);
        dchk(2, 1'b0, 1);
        dchk(1, 1'b0, S);
        dchk(0, 1'b0, S);
        `CHK("panel_fault", 1'b0, fault)
    endtask : t_indep
    task automatic t_midreset();
        wr(REG, 32'h0100_0000);
        repeat (4) @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        `CHK("outs_rst", 4'h0, outs)
        rd_chk(REG, 32'h0000_0000);
    endtask : t_midreset
    task automatic end_sim();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (3000) @(posedge clock);
        failures++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        t_regs();
        t_ext();
        t_up_down();
        t_indep();
        t_midreset();
        end_sim();
    end
endmodule : pps_panel_power_sequencer_tb
bind pps_panel_power_sequencer pps_seq_checker #(.SHORT_COUNT(SHORT_COUNT))
    pps_seq_checker_inst (.clock(clock), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .panel_supply_enable(panel_supply_enable),
    .panel_data_enable(panel_data_enable),
    .panel_contrast_enable(panel_contrast_enable),
    .backlight_off_n(backlight_off_n), .sequence_busy(sequence_busy));
`default_nettype wire

// ==== tb/pps_seq_checker.sv ====
// Purpose: port checks for the panel power sequencer
// Assumes: single clock, sync active-high reset
// Notes:   bound from the testbench top file
`timescale 1ns/10ps
`default_nettype none
module pps_seq_checker #(
    parameter int SHORT_COUNT = 10
) (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        panel_supply_enable,
    input wire logic        panel_data_enable,
    input wire logic        panel_contrast_enable,
    input wire logic        backlight_off_n,
    input wire logic        sequence_busy
);
    // skew allowance: one cycle short of the short phase
    localparam int GAP = SHORT_COUNT - 1;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    // ----
    // checks
    // ----
    a_ack_next:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_ack_pulse:
        assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_unmapped_zero:
        assert property (wb_ack_o && $past(wb_adr_i) != 12'h408
            |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not 0");
    a_reserved_zero:
        assert property (wb_ack_o |-> (wb_dat_o & 32'hF403_FFFF) == 0)
        else $error("reserved bits read nonzero");
    a_reset_off:
        assert property ($fell(reset) |-> !(panel_supply_enable ||
            panel_data_enable || panel_contrast_enable || backlight_off_n ||
            sequence_busy || wb_ack_o)) else $error("panel not off at reset");
    a_data_delay:
        assert property ($rose(panel_data_enable) && sequence_busy
            |-> $past(panel_supply_enable, GAP)) else $error("data too early");
    a_contrast_order:
        assert property ($rose(panel_contrast_enable) && sequence_busy
            |-> panel_data_enable) else $error("contrast before data");
    a_backlight_last:
        assert property ($rose(backlight_off_n) |-> panel_contrast_enable)
        else $error("backlight before contrast");
    a_supply_last:
        assert property ($fell(panel_supply_enable) |-> !panel_data_enable)
        else $error("supply dropped under data");
    a_data_off_order:
        assert property ($fell(panel_data_enable) && sequence_busy
            |-> !panel_contrast_enable) else $error("data off under contrast");
    c_up_done: cover property ($rose(backlight_off_n));
    c_down_done: cover property ($fell(panel_supply_enable));
    c_busy: cover property ($rose(sequence_busy));
endmodule : pps_seq_checker
`default_nettype wire

// ==== verilog/pps_map.svh ====
// Purpose: register map and timing constants for the panel power sequencer
// Assumes: 10 MHz device clock
// Notes:   definitions only
`ifndef PPS_MAP_SVH
`define PPS_MAP_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PPS_REG_PANEL_POWER_MANAGEMENT 12'h408
`define PPS_RESET_VALUE                32'h0000_0000
`define PPS_WRITE_MASK                 32'h0BFC_0000
`define PPS_BIT_SOURCE_SELECT          27
`define PPS_BIT_BACKLIGHT_SOURCE       25
`define PPS_BIT_POWER_REQUEST          24
`define PPS_BIT_UP_SUPPLY_TO_DATA      23
`define PPS_BIT_UP_DATA_TO_CONTRAST    22
`define PPS_BIT_UP_CONTRAST_TO_BL      21
`define PPS_BIT_DN_BL_TO_CONTRAST      20
`define PPS_BIT_DN_CONTRAST_TO_DATA    19
`define PPS_BIT_DN_DATA_TO_SUPPLY      18
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PPS_CLOCK_HZ                   10000000
`define PPS_SHORT_MS                   32
`define PPS_LONG_MS                    128
`define PPS_SHORT_CYCLES ((`PPS_SHORT_MS * `PPS_CLOCK_HZ) / 1000)
`define PPS_LONG_CYCLES  ((`PPS_LONG_MS * `PPS_CLOCK_HZ) / 1000)
`endif

// ==== verilog/pps_panel_power_sequencer.sv ====
// Purpose: panel power sequencer with a classic wishbone register slave
// Assumes: 10 MHz clock, synchronous active-high reset
// Notes:   one register, all other offsets read zero and ack
//
// Functional notes
// RQ1: bit 27 selects internal or external sequencing
// RQ2: internal mode drives all four panel controls
// RQ3: request 0 to 1 starts power-up
// RQ4: request 1 to 0 starts power-down
// RQ5: request bit always readable as panel state
// RQ6: each phase bit picks 32 or 128 ms
// RQ7: bit 25 forces backlight off immediately
// RQ8: external mode writes start no sequence
// RQ9: power-up order supply, data, contrast, backlight
// RQ10: power-down order backlight, contrast, data, supply
// RQ11: independent backlight skips bits 21 and 20 delays
// RQ12: external mode passes supply and contrast inputs
// RQ13: unchanged request starts nothing; clock-derived counter
// RQ14: reset gives idle internal mode, panel off
`timescale 1ns/10ps
`default_nettype none
`include "pps_map.svh"
module pps_panel_power_sequencer #(
    parameter int SHORT_COUNT = `PPS_SHORT_CYCLES,
    parameter int LONG_COUNT  = `PPS_LONG_CYCLES,
    parameter int TIMER_WIDTH = 21
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        ext_supply_request_in,
    input  wire logic        ext_contrast_request_in,
    output logic             panel_supply_enable,
    output logic             panel_data_enable,
    output logic             panel_contrast_enable,
    output logic             backlight_off_n,
    output logic             sequence_busy
);
    logic [31:0]        control;
    pps_pkg::pps_state_t state;
    logic               request_edge_up;
    logic               request_edge_down;
    logic               timer_start;
    logic               timer_long;
    logic               timer_done;
    logic               bus_hit;
    logic               bus_write;
    logic [31:0]        next_control;
    logic               sequence_source_select;
    logic               backlight_control_source;
    logic               panel_power_request;

    assign sequence_source_select   = control[`PPS_BIT_SOURCE_SELECT];
    assign backlight_control_source = control[`PPS_BIT_BACKLIGHT_SOURCE];
    assign panel_power_request      = control[`PPS_BIT_POWER_REQUEST];

    // ----------------------------------------------------------------
    // wishbone slave
    // ----------------------------------------------------------------
    assign bus_hit   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_write = bus_hit && wb_we_i &&
                       wb_adr_i == `PPS_REG_PANEL_POWER_MANAGEMENT;

    always_comb begin
        next_control = control;
        for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) begin
                next_control[i*8 +: 8] = wb_dat_i[i*8 +: 8];
            end
        end
        next_control = next_control & `PPS_WRITE_MASK;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `PPS_RESET_VALUE;
        end else begin
            // one wait state, ack drops the cycle after
            wb_ack_o <= bus_hit;
            if (bus_hit && !wb_we_i &&
                wb_adr_i == `PPS_REG_PANEL_POWER_MANAGEMENT) begin
                wb_dat_o <= control; // RQ5
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            control <= `PPS_RESET_VALUE; // RQ14
        end else if (bus_write) begin
            control <= next_control;
        end
    end

    // only real transitions of the request bit count
    assign request_edge_up   = bus_write && !sequence_source_select &&
        !next_control[`PPS_BIT_SOURCE_SELECT] && !panel_power_request &&
        next_control[`PPS_BIT_POWER_REQUEST]; // RQ3 RQ8 RQ13
    assign request_edge_down = bus_write && !sequence_source_select &&
        !next_control[`PPS_BIT_SOURCE_SELECT] && panel_power_request &&
        !next_control[`PPS_BIT_POWER_REQUEST]; // RQ4 RQ8 RQ13

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // a reversed request mid-sequence restarts the other sequence from its first step
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= pps_pkg::PPS_OFF; // RQ14
        end else if (sequence_source_select) begin
            state <= pps_pkg::PPS_OFF; // RQ1
        end else if (request_edge_up) begin
            state <= pps_pkg::PPS_UP_DATA; // RQ3 RQ9
        end else if (request_edge_down) begin
            // independent backlight skips the first down delay
            state <= backlight_control_source ? pps_pkg::PPS_DN_DATA
                                              : pps_pkg::PPS_DN_CON; // RQ11
        end else if (timer_done) begin
            case (state)
                pps_pkg::PPS_UP_DATA: state <= pps_pkg::PPS_UP_CON;
                pps_pkg::PPS_UP_CON:  state <= backlight_control_source ?
                    pps_pkg::PPS_ON : pps_pkg::PPS_UP_BL; // RQ11
                pps_pkg::PPS_UP_BL:   state <= pps_pkg::PPS_ON;
                pps_pkg::PPS_DN_CON:  state <= pps_pkg::PPS_DN_DATA;
                pps_pkg::PPS_DN_DATA: state <= pps_pkg::PPS_DN_SUP; // RQ10
                pps_pkg::PPS_DN_SUP:  state <= pps_pkg::PPS_OFF; // RQ10
                default:              state <= state;
            endcase
        end
    end

    // the timer runs once per step, picked by the step's own bit
    always_comb begin
        timer_start = request_edge_up || request_edge_down ||
            (timer_done && (state == pps_pkg::PPS_UP_DATA ||
             (state == pps_pkg::PPS_UP_CON && !backlight_control_source) ||
             state == pps_pkg::PPS_DN_CON ||
             state == pps_pkg::PPS_DN_DATA)); // RQ13
        timer_long = 1'b0;
        if (request_edge_up) begin
            timer_long = control[`PPS_BIT_UP_SUPPLY_TO_DATA]; // RQ6
        end else if (request_edge_down) begin
            timer_long = backlight_control_source ?
                control[`PPS_BIT_DN_CONTRAST_TO_DATA] :
                control[`PPS_BIT_DN_BL_TO_CONTRAST]; // RQ6
        end else begin
            case (state)
                pps_pkg::PPS_UP_DATA:
                    timer_long = control[`PPS_BIT_UP_DATA_TO_CONTRAST];
                pps_pkg::PPS_UP_CON:
                    timer_long = control[`PPS_BIT_UP_CONTRAST_TO_BL];
                pps_pkg::PPS_DN_CON:
                    timer_long = control[`PPS_BIT_DN_CONTRAST_TO_DATA];
                pps_pkg::PPS_DN_DATA:
                    timer_long = control[`PPS_BIT_DN_DATA_TO_SUPPLY];
                default:
                    timer_long = 1'b0;
            endcase
        end
    end

    // request edges use the phase bits being written
    pps_phase_timer #(
        .WIDTH       (TIMER_WIDTH),
        .SHORT_COUNT (SHORT_COUNT),
        .LONG_COUNT  (LONG_COUNT)
    ) u_timer (
        .clock    (clock),
        .reset    (reset),
        .start    (timer_start),
        .long_sel (request_edge_up ?
                   next_control[`PPS_BIT_UP_SUPPLY_TO_DATA] :
                   request_edge_down ?
                   (backlight_control_source ?
                    next_control[`PPS_BIT_DN_CONTRAST_TO_DATA] :
                    next_control[`PPS_BIT_DN_BL_TO_CONTRAST]) :
                   timer_long),
        .cancel   (sequence_source_select),
        .done     (timer_done)
    );

    // ----------------------------------------------------------------
    // panel outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            panel_supply_enable   <= 1'b0; // RQ14
            panel_data_enable     <= 1'b0;
            panel_contrast_enable <= 1'b0;
            backlight_off_n       <= 1'b0;
            sequence_busy         <= 1'b0;
        end else if (sequence_source_select) begin
            panel_supply_enable   <= ext_supply_request_in; // RQ12
            panel_contrast_enable <= ext_contrast_request_in; // RQ12
            panel_data_enable     <= ext_supply_request_in;
            backlight_off_n       <= !backlight_control_source &&
                                     ext_contrast_request_in; // RQ7
            sequence_busy         <= 1'b0;
        end else begin
            panel_supply_enable   <= state != pps_pkg::PPS_OFF; // RQ2 RQ9
            panel_data_enable     <= !(state == pps_pkg::PPS_OFF ||
                state == pps_pkg::PPS_UP_DATA ||
                state == pps_pkg::PPS_DN_SUP); // RQ9 RQ10
            panel_contrast_enable <= state == pps_pkg::PPS_UP_BL ||
                state == pps_pkg::PPS_ON ||
                state == pps_pkg::PPS_DN_CON; // RQ9 RQ10
            backlight_off_n       <= state == pps_pkg::PPS_ON &&
                !backlight_control_source; // RQ7 RQ10
            sequence_busy         <= !(state == pps_pkg::PPS_OFF ||
                state == pps_pkg::PPS_ON);
        end
    end
endmodule : pps_panel_power_sequencer
`default_nettype wire

// ==== verilog/pps_phase_timer.sv ====
// Purpose: phase delay counter for the panel power sequencer
// Assumes: start is a one-cycle pulse
// Notes:   done pulses once when the loaded count expires
`timescale 1ns/10ps
`default_nettype none
module pps_phase_timer #(
    parameter int WIDTH       = 21,
    parameter int SHORT_COUNT = 320000,
    parameter int LONG_COUNT  = 1280000
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic start,
    input  wire logic long_sel,
    input  wire logic cancel,
    output logic      done
);
    logic [WIDTH-1:0] count;
    logic             running;

    // ----------------------------------------------------------------
    // countdown
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset || cancel) begin
            count   <= '0;
            running <= 1'b0;
            done    <= 1'b0;
        end else if (start) begin
            // load minus one so done lands exactly on the count
            count   <= long_sel ? WIDTH'(LONG_COUNT - 1)
                                : WIDTH'(SHORT_COUNT - 1);
            running <= 1'b1;
            done    <= 1'b0;
        end else if (running && count == '0) begin
            running <= 1'b0;
            done    <= 1'b1;
        end else begin
            count   <= running ? count - WIDTH'(1) : count;
            done    <= 1'b0;
        end
    end
endmodule : pps_phase_timer
`default_nettype wire

// ==== verilog/pps_pkg.sv ====
// Purpose: types for the panel power sequencer
// Assumes: nothing
// Notes:   one-hot sequencer states
`default_nettype none
package pps_pkg;
    typedef enum logic [7:0] {
        PPS_OFF       = 8'b0000_0001,
        PPS_UP_DATA   = 8'b0000_0010,
        PPS_UP_CON    = 8'b0000_0100,
        PPS_UP_BL     = 8'b0000_1000,
        PPS_ON        = 8'b0001_0000,
        PPS_DN_CON    = 8'b0010_0000,
        PPS_DN_DATA   = 8'b0100_0000,
        PPS_DN_SUP    = 8'b1000_0000
    } pps_state_t;
endpackage : pps_pkg
`default_nettype wire
